/* File: design/scan_tap.sv */
// Boundary-scan test access port of a pipelined memory, sampled on REF_CLK.
`timescale 1ns/1ns
`default_nettype none
module scan_tap
  import scan_tap_pkg::*;
#(
  parameter int          RING_LEN  = RING_WIDE,
  parameter logic [3:0]  ID_REV    = 4'h1,  // Arbitrary identity value.
  parameter logic [3:0]  ID_PART   = 4'h2,  // Arbitrary identity value.
  parameter logic [5:0]  ID_TYPE   = 6'h03, // Arbitrary identity value.
  parameter logic [5:0]  ID_WD     = 6'h04, // Arbitrary identity value.
  parameter logic [11:0] ID_VEND   = 12'h055 // Arbitrary identity value.
) (
  input  wire logic                REF_CLK,
  input  wire logic                RESETN,
  input  wire logic                CLK_EN,
  input  wire logic                TCK,
  input  wire logic                TMS,
  input  wire logic                TDI,
  input  wire logic [RING_LEN-1:0] PIN_RING,
  output var  logic                TDO,
  output var  logic                TDO_OE_N,
  output var  logic                MEM_FLOAT
);

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_prev_q;
  logic rise;
  logic fall;

  pin_sync u_tck (.clk(REF_CLK), .rst_n(RESETN), .ce(CLK_EN), .d(TCK), .q(tck_s));
  pin_sync u_tms (.clk(REF_CLK), .rst_n(RESETN), .ce(CLK_EN), .d(TMS), .q(tms_s));
  pin_sync u_tdi (.clk(REF_CLK), .rst_n(RESETN), .ce(CLK_EN), .d(TDI), .q(tdi_s));

  // The ring is a snapshot of pins in another clock domain, so it passes two stages as well.
  // A pin that moves during capture may be caught either way; the user must hold it steady.
  logic [RING_LEN-1:0] ring_meta_q;
  logic [RING_LEN-1:0] ring_sync_q;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ring_meta_q <= '0;
      ring_sync_q <= '0;
    end else if (CLK_EN) begin
      ring_meta_q <= PIN_RING;
      ring_sync_q <= ring_meta_q;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tck_prev_q <= 1'b0;
    end else if (CLK_EN) begin
      tck_prev_q <= tck_s;
    end
  end

  // Edges are seen two REF_CLK cycles late; TMS and TDI are delayed alike, so they line up.
  assign rise = CLK_EN & tck_s & ~tck_prev_q;
  assign fall = CLK_EN & ~tck_s & tck_prev_q;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  tap_state_t state_q;
  tap_state_t state_d;

  always_comb begin
    case (state_q)
      ST_RESET:  state_d = tms_s ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_d = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = tms_s ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  state_d = tms_s ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_d = tms_s ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms_s ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_d = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = tms_s ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  state_d = tms_s ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_d = tms_s ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      default:   state_d = ST_RESET;
    endcase
  end

  // Five high mode samples reach ST_RESET from any state through this table.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_RESET;
    end else if (rise) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Instruction path
  // ----------------------------------------
  logic [IR_LEN-1:0] ir_shift_q;
  logic [IR_LEN-1:0] ir_q;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ir_shift_q <= IR_RESET;
    end else if (rise) begin
      case (state_q)
        ST_CAP_IR: ir_shift_q <= {ir_shift_q[IR_LEN-1:2], IR_CAPTURE};
        ST_SH_IR:  ir_shift_q <= {tdi_s, ir_shift_q[IR_LEN-1:1]};
        default:   ir_shift_q <= ir_shift_q;
      endcase
    end
  end

  // The identity read is restored on the edge that enters reset, so a fifth high mode sample
  // from the farthest state already releases the memory outputs.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ir_q <= IR_RESET;
    end else if (rise) begin
      if (state_d == ST_RESET) begin
        ir_q <= IR_RESET;
      end else if (state_q == ST_UP_IR) begin
        ir_q <= ir_shift_q;
      end
    end
  end

  // ----------------------------------------
  // Data paths
  // ----------------------------------------
  logic                skip_q;
  logic [ID_LEN-1:0]   id_q;
  logic [RING_LEN-1:0] ring_q;
  logic                use_ring;
  logic [ID_LEN-1:0]   id_word;

  // Reserved codes fall to the skip path; the controller must not load them.
  assign use_ring = (ir_q == INS_EXTEST) | (ir_q == INS_SAMPLEZ) | (ir_q == INS_SAMPLE);
  assign id_word  = {ID_REV, ID_PART, ID_TYPE, ID_WD, ID_VEND};

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      skip_q <= 1'b0;
    end else if (rise) begin
      if (state_q == ST_CAP_DR) begin
        skip_q <= 1'b0;
      end else if (state_q == ST_SH_DR) begin
        skip_q <= tdi_s;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      id_q <= '0;
    end else if (rise && (ir_q == INS_IDCODE)) begin
      if (state_q == ST_CAP_DR) begin
        id_q <= id_word;
      end else if (state_q == ST_SH_DR) begin
        id_q <= {tdi_s, id_q[ID_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ring_q <= '0;
    end else if (rise && use_ring) begin
      if (state_q == ST_CAP_DR) begin
        ring_q <= ring_sync_q;
      end else if (state_q == ST_SH_DR) begin
        ring_q <= {tdi_s, ring_q[RING_LEN-1:1]};
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // The ring is never driven onto pins, so the update state has no effect on them.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      MEM_FLOAT <= 1'b0;
    end else if (CLK_EN) begin
      MEM_FLOAT <= (ir_q == INS_EXTEST) | (ir_q == INS_SAMPLEZ);
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      TDO      <= 1'b0;
      TDO_OE_N <= 1'b1;
    end else if (fall) begin
      TDO_OE_N <= ~((state_q == ST_SH_DR) | (state_q == ST_SH_IR));
      if (state_q == ST_SH_IR) begin
        TDO <= ir_shift_q[0];
      end else if (use_ring) begin
        TDO <= ring_q[0];
      end else if (ir_q == INS_IDCODE) begin
        TDO <= id_q[0];
      end else begin
        TDO <= skip_q;
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/scan_tap_pkg.sv */
// Package with constants and types of the memory boundary-scan test port.
package scan_tap_pkg;

  // ----------------------------------------
  // Scan path lengths and the mode-high count for reset
  // ----------------------------------------
  localparam int IR_LEN       = 3;
  localparam int ID_LEN       = 32;
  localparam int RING_NARROW  = 51;
  localparam int RING_WIDE    = 70;
  localparam int RESET_TMS_N  = 5;

  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [2:0] INS_EXTEST   = 3'h0;
  localparam logic [2:0] INS_IDCODE   = 3'h1;
  localparam logic [2:0] INS_SAMPLEZ  = 3'h2;
  localparam logic [2:0] INS_SAMPLE   = 3'h4;
  localparam logic [2:0] INS_BYPASS   = 3'h7;
  localparam logic [2:0] IR_RESET     = INS_IDCODE;
  localparam logic [1:0] IR_CAPTURE   = 2'h1;

  // ----------------------------------------
  // Identification field positions
  // ----------------------------------------
  localparam int ID_REV_LSB   = 28;
  localparam int ID_PART_LSB  = 24;
  localparam int ID_TYPE_LSB  = 18;
  localparam int ID_WD_LSB    = 12;
  localparam int ID_VEND_LSB  = 0;

  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h2,
    ST_CAP_DR  = 4'h3,
    ST_SH_DR   = 4'h4,
    ST_EX1_DR  = 4'h5,
    ST_PA_DR   = 4'h6,
    ST_EX2_DR  = 4'h7,
    ST_UP_DR   = 4'h8,
    ST_SEL_IR  = 4'h9,
    ST_CAP_IR  = 4'hA,
    ST_SH_IR   = 4'hB,
    ST_EX1_IR  = 4'hC,
    ST_PA_IR   = 4'hD,
    ST_EX2_IR  = 4'hE,
    ST_UP_IR   = 4'hF
  } tap_state_t;

endpackage

/* File: design/pin_sync.sv */
// Two-stage synchroniser for one asynchronous pin.
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic d,
  output var  logic q
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: tb/scan_tap_sva.sv */
// Checker on the outputs of the boundary-scan port.
`timescale 1ns/1ns
`default_nettype none
module scan_tap_sva
  import scan_tap_pkg::*;
#(
  parameter int RING_LEN = RING_WIDE
) (
  input wire logic                REF_CLK,
  input wire logic                RESETN,
  input wire logic                CLK_EN,
  input wire logic                TCK,
  input wire logic                TMS,
  input wire logic                TDI,
  input wire logic [RING_LEN-1:0] PIN_RING,
  input wire logic                TDO,
  input wire logic                TDO_OE_N,
  input wire logic                MEM_FLOAT
);
  logic       tck_q;
  logic [2:0] ones_q;
  logic [2:0] fall_cnt_q;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // Rising test-clock edges in a row with mode high, held at five.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tck_q      <= 1'b0;
      ones_q     <= 3'h0;
      fall_cnt_q <= 3'h7;
    end else begin
      tck_q <= TCK;
      // Enabled clock edges since the test clock pin was seen to fall, held at seven.
      if (tck_q && !TCK) begin
        fall_cnt_q <= {2'h0, CLK_EN};
      end else if (CLK_EN && (fall_cnt_q != 3'h7)) begin
        fall_cnt_q <= fall_cnt_q + 3'h1;
      end
      if (TCK && !tck_q) begin
        ones_q <= !TMS ? 3'h0 : (ones_q == 3'h5 ? 3'h5 : ones_q + 3'h1);
      end
    end
  end
  AST_TDO_ON_FALL: assert property ($changed(TDO) |-> !TCK && (fall_cnt_q == 3'h3))
    else $error("data out moved off a falling edge");
  AST_OE_ON_FALL: assert property ($changed(TDO_OE_N) |-> !TCK && (fall_cnt_q == 3'h3))
    else $error("enable moved off a falling edge");
  AST_FLOAT_NOT_IN_SHIFT: assert property ($changed(MEM_FLOAT) |-> TDO_OE_N)
    else $error("float changed while shifting");
  AST_IDLE_QUIET: assert property (!TCK [*8] |-> $stable(TDO) && $stable(TDO_OE_N))
    else $error("outputs moved with test clock still");
  AST_FREEZE: assert property (!CLK_EN |=> $stable(TDO_OE_N) && $stable(MEM_FLOAT))
    else $error("outputs moved while frozen");
  AST_TMS_RESET: assert property (ones_q == 3'h5 |-> ##[0:8] (!MEM_FLOAT && TDO_OE_N))
    else $error("five mode-high edges did not reset");
  AST_RST_QUIET: assert property (disable iff (1'b0) !RESETN |=> TDO_OE_N && !MEM_FLOAT)
    else $error("outputs active in reset");
  AST_RST_TDO: assert property (disable iff (1'b0) !RESETN |-> ##1 !TDO)
    else $error("data out not low in reset");
endmodule
bind scan_tap scan_tap_sva #(.RING_LEN(RING_LEN)) sva_i (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .TCK(TCK), .TMS(TMS), .TDI(TDI),
  .PIN_RING(PIN_RING), .TDO(TDO), .TDO_OE_N(TDO_OE_N), .MEM_FLOAT(MEM_FLOAT)
);
`default_nettype wire

/* File: tb/jtag_ctl.sv */
// Board test controller model that clocks the scan link.
`timescale 1ns/1ns
`default_nettype none
module jtag_ctl (
  input  wire logic clk,
  input  wire logic TDO,
  input  wire logic TDO_OE_N,
  output var  logic TCK,
  output var  logic TMS,
  output var  logic TDI
);
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // One 64 ns test clock; it stands low between calls.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge clk);
    TMS = tms;
    TDI = tdi;
    repeat (3) @(negedge clk);
    tdo = TDO_OE_N ? 1'bx : TDO;
    TCK = 1'b1;
    repeat (4) @(negedge clk);
    TCK = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/memory_boundary_scan_tap_bench.sv */
// Self-checking bench of the boundary-scan port.
`timescale 1ns/1ns
`default_nettype none
module memory_boundary_scan_tap_bench;
  import scan_tap_pkg::*;
  localparam logic [31:0] ID = {4'h1, 4'h2, 6'h03, 6'h04, 12'h055};
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        clk_en  = 1'b1;
  logic [50:0] ring    = '0;
  logic [31:0] rng     = 32'h7D13;
  logic [69:0] got;
  int          errors  = 0;
  int          checked = 0;
  logic [2:0]  codes [5] = '{INS_EXTEST, INS_SAMPLEZ, INS_SAMPLE, INS_BYPASS, INS_IDCODE};
  wire logic   tck, tms, tdi, tdo, tdo_oe_n, mem_float;
  always #4 ref_clk = ~ref_clk;
  scan_tap #(.RING_LEN(RING_NARROW)) DUT (.REF_CLK(ref_clk), .RESETN(resetn), .CLK_EN(clk_en),
    .TCK(tck), .TMS(tms), .TDI(tdi), .PIN_RING(ring), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
    .MEM_FLOAT(mem_float));
  jtag_ctl ctl (.clk(ref_clk), .TDO(tdo), .TDO_OE_N(tdo_oe_n), .TCK(tck), .TMS(tms), .TDI(tdi));
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic check(input string nm, input logic [69:0] seen, input logic [69:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Shifts n bits, leaves through update and parks in idle.
  task automatic scan(input int n, input logic [69:0] din);
    logic b;
    got = '0;
    for (int i = 0; i < n; i++) begin
      ctl.step(i == n - 1, din[i], b);
      got[i] = b;
    end
    ctl.step(1'b1, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
  endtask
  // The selected path is modelled as a bit queue: captured word first, shifted-in bits after.
  task automatic run(input logic [2:0] code, input bit load);
    logic        b;
    logic [69:0] din;
    logic [69:0] cap;
    logic [69:0] exp;
    bit          model [$];
    int          len;
    if (load) begin
      ctl.step(1'b1, 1'b0, b);
      ctl.step(1'b1, 1'b0, b);
      ctl.step(1'b0, 1'b0, b);
      ctl.step(1'b0, 1'b0, b);
      scan(3, {67'h0, code});
      check("ir_capture", got[1:0], IR_CAPTURE);
    end
    check("mem_float", mem_float, code == INS_EXTEST || code == INS_SAMPLEZ);
    ring = 51'({rnd(), rnd()});
    din  = 70'({rnd(), rnd(), rnd()});
    len  = code == INS_BYPASS ? 1 : code == INS_IDCODE ? ID_LEN : RING_NARROW;
    cap  = code == INS_BYPASS ? 70'h0 : code == INS_IDCODE ? 70'(ID) : 70'(ring);
    exp  = '0;
    model = {};
    for (int i = 0; i < len; i++) model.push_back(cap[i]);
    for (int i = 0; i <= len; i++) begin
      exp[i] = model.pop_front();
      model.push_back(din[i]);
    end
    repeat (4) @(negedge ref_clk);
    clk_en = 1'b0;
    repeat (3) @(negedge ref_clk);
    clk_en = 1'b1;
    ctl.step(1'b1, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
    scan(len + 1, din);
    check("dr_path", got, exp);
  endtask
  initial begin
    logic b;
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    check("oe_n", tdo_oe_n, 1'b1);
    ctl.step(1'b0, 1'b0, b);
    run(INS_IDCODE, 1'b0);
    foreach (codes[k]) run(codes[k], 1'b1);
    run(INS_EXTEST, 1'b1);
    repeat (5) ctl.step(1'b1, 1'b0, b);
    repeat (4) @(negedge ref_clk);
    check("tms_reset", mem_float, 1'b0);
    ctl.step(1'b0, 1'b0, b);
    run(INS_IDCODE, 1'b0);
    close_out();
  end
  initial begin
    #300000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
